// *** hw/cls_loader.sv ***
// copies the configuration flash image into the configuration cells
`timescale 1ns/10ps
`include "cls_defs.svh"
module cls_loader (
    input wire logic clk,
    input wire logic rst,
    cls_load_if.ldr lb,
    output logic [`CLS_CELLS_W-1:0] cells
);
    // ---------------------------------------------------------------
    // word walker
    // ---------------------------------------------------------------
    logic busy;
    logic [`CLS_AW-1:0] idx;
    logic done;
    logic [`CLS_DW-1:0] cell_mem [`CLS_WORDS];

    assign lb.addr = idx;
    assign lb.done = done;

    // busy from start until the last word is copied
    always_ff @(posedge clk)
    begin
        if (rst)
            busy <= 1'b0;
        else if (lb.start)
            busy <= 1'b1;
        else if (busy && idx == `CLS_LAST)
            busy <= 1'b0;
    end

    // word index
    always_ff @(posedge clk)
    begin
        if (rst || lb.start)
            idx <= '0;
        else if (busy)
            idx <= idx + 3'h1;
    end

    // done pulse after the last word
    always_ff @(posedge clk)
    begin
        if (rst)
            done <= 1'b0;
        else
            done <= busy && idx == `CLS_LAST;
    end

    // ---------------------------------------------------------------
    // configuration cells, cleared by reset and otherwise written only by a load, never read back
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `CLS_WORDS; i++)
                cell_mem[i] <= `CLS_CELL_RST;
        end
        else if (busy)
            cell_mem[idx] <= lb.rdata; // [RQ2]
    end

    // cells fan out to the logic array only
    genvar g;
    generate
        for (g = 0; g < `CLS_WORDS; g++)
        begin : g_pack
            assign cells[g*`CLS_DW +: `CLS_DW] = cell_mem[g]; // [RQ7]
        end
    endgenerate

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_load_span: assert property (@(posedge clk) disable iff (rst) // [RQ10]
        lb.start && !busy |=> busy [*8] ##1 (!busy && done))
        else $error("load did not copy exactly eight words");
endmodule

// *** hw/cls_top.sv ***
// configuration load, reload and design security sequencer
// Operation
// RQ1: programming the flash leaves the running cells and pins untouched.
// RQ2: a new flash image reaches the cells only through a fresh load.
// RQ3: reload-arm then reload-go commands restart loading without power cycle.
// RQ4: during a commanded reload every pin is undriven with pull-up on.
// RQ5: with security set, configuration flash reads are refused.
// RQ6: the security bit clears only by a device erase.
// RQ7: no read path exists to the configuration cells.
// RQ8: user flash stays readable over the port and from the array.
// RQ9: outputs stay off until supplies are good and configuration completes.
// RQ10: power-on logic keeps pins undriven until the flash copy finishes.
// RQ11: weak pull-ups stay on during the whole configuration download.
// RQ12: a low core or I/O supply raises supply-low, forcing outputs off.
// RQ13: I/O-before-core or pad above I/O supply keeps outputs off.
// RQ14: user registers are cleared and released before pins are released.
// RQ15: pins never drive until the programming-complete bit is programmed.
// RQ16: one configuration-done flag and supply-low together gate output enables.
`timescale 1ns/10ps
`include "cls_defs.svh"
module cls_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic vccint_ok,
    input wire logic vccio_ok,
    input wire logic pad_over_vccio,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic [`CLS_AW-1:0] cmd_addr,
    input wire logic [`CLS_DW-1:0] cmd_data,
    output logic rsp_valid,
    output logic [`CLS_DW-1:0] rsp_data,
    output logic rsp_refused,
    input wire logic ua_rd,
    input wire logic [`CLS_AW-1:0] ua_addr,
    output logic ua_valid,
    output logic [`CLS_DW-1:0] ua_data,
    output logic io_oe_n,
    output logic io_pullup,
    output logic user_clr,
    output logic supply_low_output_block,
    output logic cfg_done,
    output logic [`CLS_CELLS_W-1:0] cfg_cells
);
    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    function automatic logic op_is(
        input logic v,
        input logic [3:0] op,
        input cls_pkg::cls_op_t want
    );
        return v && (op == want);
    endfunction

    logic do_erase;
    logic do_pcfg;
    logic do_pufm;
    logic do_psec;
    logic do_pdone;
    logic do_rcfg;
    logic do_rufm;
    logic do_arm;
    logic do_go;

    assign do_erase = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_ERASE);
    assign do_pcfg = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_PROG_CFG);
    assign do_pufm = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_PROG_UFM);
    assign do_psec = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_PROG_SEC);
    assign do_pdone = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_PROG_DONE);
    assign do_rcfg = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_READ_CFG);
    assign do_rufm = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_READ_UFM);
    assign do_arm = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_RELOAD_ARM);
    assign do_go = op_is(cmd_valid, cmd_op, cls_pkg::CLS_OP_RELOAD_GO);

    // ---------------------------------------------------------------
    // non-volatile storage
    // ---------------------------------------------------------------
    logic [`CLS_DW-1:0] cfg_mem [`CLS_WORDS];
    logic [`CLS_DW-1:0] ufm_mem [`CLS_WORDS];
    logic security_bit;
    logic programming_complete_bit;

    // configuration flash: programmed in the background, cells untouched
    always_ff @(posedge clk)
    begin
        if (do_erase)
        begin
            for (int i = 0; i < `CLS_WORDS; i++)
                cfg_mem[i] <= `CLS_ERASED;
        end
        else if (do_pcfg)
            cfg_mem[cmd_addr] <= cmd_data; // [RQ1]
    end

    // user flash
    always_ff @(posedge clk)
    begin
        if (do_erase)
        begin
            for (int i = 0; i < `CLS_WORDS; i++)
                ufm_mem[i] <= `CLS_ERASED;
        end
        else if (do_pufm)
            ufm_mem[cmd_addr] <= cmd_data;
    end

    // security bit: set by programming, cleared by erase alone
    always_ff @(posedge clk)
    begin
        if (do_erase)
            security_bit <= `CLS_BIT_CLEAR; // [RQ6]
        else if (do_psec)
            security_bit <= `CLS_BIT_SET;
    end

    // programming-complete bit, the last bit an image writes
    always_ff @(posedge clk)
    begin
        if (do_erase)
            programming_complete_bit <= `CLS_BIT_CLEAR;
        else if (do_pdone)
            programming_complete_bit <= `CLS_BIT_SET; // [RQ15]
    end

    // ---------------------------------------------------------------
    // read answers
    // ---------------------------------------------------------------
    // port reads: configuration flash behind security, user flash open
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid <= 1'b0;
            rsp_refused <= 1'b0;
            rsp_data <= '0;
        end
        else
        begin
            rsp_valid <= do_rcfg || do_rufm;
            rsp_refused <= do_rcfg && security_bit; // [RQ5]
            if (do_rcfg)
                rsp_data <= security_bit ? '0 : cfg_mem[cmd_addr]; // [RQ5]
            else if (do_rufm)
                rsp_data <= ufm_mem[cmd_addr]; // [RQ8]
            else
                rsp_data <= '0;
        end
    end

    // logic array user flash port, ignores security
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ua_valid <= 1'b0;
            ua_data <= '0;
        end
        else
        begin
            ua_valid <= ua_rd;
            ua_data <= ua_rd ? ufm_mem[ua_addr] : '0; // [RQ8]
        end
    end

    // ---------------------------------------------------------------
    // supply watch
    // ---------------------------------------------------------------
    logic supply_low_now;
    logic drive_ok;
    logic image_complete;

    assign supply_low_now = !vccint_ok || !vccio_ok; // [RQ12]

    always_ff @(posedge clk)
    begin
        if (rst)
            supply_low_output_block <= 1'b1;
        else
            supply_low_output_block <= supply_low_now; // [RQ12]
    end

    // ---------------------------------------------------------------
    // load sequencer
    // ---------------------------------------------------------------
    cls_pkg::cls_state_t state;
    cls_pkg::cls_state_t next_state;
    logic reload_armed;
    cls_load_if lb ();

    assign lb.rdata = cfg_mem[lb.addr];

    // arm holds until the next command, however many idle clocks pass
    always_ff @(posedge clk)
    begin
        if (rst)
            reload_armed <= 1'b0;
        else if (cmd_valid)
            reload_armed <= do_arm; // [RQ3]
    end

    // next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            cls_pkg::CLS_ST_WAIT_PWR:
                if (!supply_low_now)
                    next_state = cls_pkg::CLS_ST_LOAD; // [RQ9]
            cls_pkg::CLS_ST_LOAD:
                if (!vccint_ok)
                    next_state = cls_pkg::CLS_ST_WAIT_PWR;
                else if (lb.done)
                    next_state = cls_pkg::CLS_ST_CLEAR; // [RQ10]
            cls_pkg::CLS_ST_CLEAR:
                next_state = cls_pkg::CLS_ST_USER; // [RQ14]
            cls_pkg::CLS_ST_USER:
                if (!vccint_ok)
                    next_state = cls_pkg::CLS_ST_WAIT_PWR;
                else if (do_go && reload_armed)
                    next_state = cls_pkg::CLS_ST_LOAD; // [RQ3]
        endcase
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= cls_pkg::CLS_ST_WAIT_PWR;
        else
            state <= next_state;
    end

    // loader start on every entry into load
    always_ff @(posedge clk)
    begin
        if (rst)
            lb.start <= 1'b0;
        else
            lb.start <= next_state == cls_pkg::CLS_ST_LOAD
                && state != cls_pkg::CLS_ST_LOAD; // [RQ2]
    end

    cls_loader u_loader (
        .clk(clk),
        .rst(rst),
        .lb(lb),
        .cells(cfg_cells)
    );

    // ---------------------------------------------------------------
    // pin control
    // ---------------------------------------------------------------
    assign drive_ok = state == cls_pkg::CLS_ST_USER && image_complete
        && !supply_low_now && !pad_over_vccio; // [RQ13] [RQ16]

    // clear pulse, then done flag and output enables on the same edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            user_clr <= 1'b1;
            cfg_done <= 1'b0;
            image_complete <= 1'b0;
        end
        else
        begin
            user_clr <= state == cls_pkg::CLS_ST_CLEAR; // [RQ14]
            cfg_done <= state == cls_pkg::CLS_ST_USER; // [RQ16]
            if (state == cls_pkg::CLS_ST_CLEAR)
                image_complete <= programming_complete_bit; // [RQ1] [RQ15]
        end
    end

    // output enable and pull-up
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            io_oe_n <= 1'b1;
            io_pullup <= 1'b1;
        end
        else
        begin
            io_oe_n <= !drive_ok; // [RQ4] [RQ9] [RQ15]
            io_pullup <= state != cls_pkg::CLS_ST_USER; // [RQ11]
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_reload_cmd;
        do_arm ##1 (do_go && vccint_ok && state == cls_pkg::CLS_ST_USER);
    endsequence
    sequence s_read_cfg_locked;
        do_rcfg && security_bit;
    endsequence

    chk_reload_sequence: assert property (s_reload_cmd |=> // [RQ3]
        state == cls_pkg::CLS_ST_LOAD ##1 (io_oe_n && io_pullup))
        else $error("reload command did not start a load");
    chk_load_pins_off: assert property ( // [RQ4]
        state == cls_pkg::CLS_ST_LOAD |=> io_oe_n && io_pullup)
        else $error("pins driven during a load");
    chk_secure_refuse: assert property (s_read_cfg_locked |=> // [RQ5]
        rsp_valid && rsp_refused && rsp_data == '0)
        else $error("secured configuration flash was read");
    chk_secure_clear: assert property ( // [RQ6]
        $fell(security_bit) |-> $past(do_erase))
        else $error("security bit cleared without erase");
    chk_ufm_open: assert property (ua_rd |=> // [RQ8]
        ua_valid && ua_data == ufm_mem[$past(ua_addr)])
        else $error("user flash read failed");
    chk_cells_steady: assert property ( // [RQ1]
        state == cls_pkg::CLS_ST_USER && do_pcfg |=> $stable(cfg_cells))
        else $error("programming disturbed the running cells");
    chk_drive_gate: assert property (!io_oe_n |-> // [RQ9]
        cfg_done && !supply_low_output_block && image_complete)
        else $error("pins driven without configuration done");
    chk_supply_block: assert property ( // [RQ12]
        supply_low_output_block |-> io_oe_n)
        else $error("pins driven while supply low");
    chk_pad_block: assert property (pad_over_vccio |=> io_oe_n) // [RQ13]
        else $error("pins driven with pad above supply");
    chk_clear_first: assert property ($rose(cfg_done) |-> // [RQ14]
        $past(user_clr) && $past(io_oe_n))
        else $error("user registers not cleared before release");
    chk_done_bit: assert property (!image_complete |=> io_oe_n) // [RQ15]
        else $error("pins driven before programming complete");
    chk_done_latch: assert property ($rose(image_complete) |-> // [RQ15]
        $past(programming_complete_bit))
        else $error("image taken as complete without the complete bit");
endmodule

// *** include/cls_defs.svh ***
// constants for the configuration loader and security block
`ifndef CLS_DEFS_SVH
`define CLS_DEFS_SVH
// ---------------------------------------------------------------
// flash geometry
// ---------------------------------------------------------------
`define CLS_WORDS 8
`define CLS_LAST 3'h7
`define CLS_AW 3
`define CLS_DW 8
`define CLS_CELLS_W 64
// ---------------------------------------------------------------
// erased and reset values
// ---------------------------------------------------------------
`define CLS_ERASED 8'hFF
`define CLS_CELL_RST 8'h00
`define CLS_BIT_CLEAR 1'b0
`define CLS_BIT_SET 1'b1
`endif

// *** include/cls_load_if.sv ***
// carrier between the sequencer and the configuration cell loader
`timescale 1ns/10ps
`include "cls_defs.svh"
interface cls_load_if;
    logic start;
    logic done;
    logic [`CLS_AW-1:0] addr;
    logic [`CLS_DW-1:0] rdata;
    modport ctl (output start, output rdata, input done, input addr);
    modport ldr (input start, input rdata, output done, output addr);
endinterface

// *** include/cls_pkg.sv ***
// types for the configuration loader and security block
package cls_pkg;
    // control state of the power-up and reload sequence
    typedef enum logic [1:0] {
        CLS_ST_WAIT_PWR = 2'b00,
        CLS_ST_LOAD = 2'b01,
        CLS_ST_CLEAR = 2'b10,
        CLS_ST_USER = 2'b11
    } cls_state_t;

    // programming port operations
    typedef enum logic [3:0] {
        CLS_OP_NOP = 4'b0000,
        CLS_OP_ERASE = 4'b0001,
        CLS_OP_PROG_CFG = 4'b0010,
        CLS_OP_PROG_UFM = 4'b0011,
        CLS_OP_PROG_SEC = 4'b0100,
        CLS_OP_PROG_DONE = 4'b0101,
        CLS_OP_READ_CFG = 4'b0110,
        CLS_OP_READ_UFM = 4'b0111,
        CLS_OP_RELOAD_ARM = 4'b1000,
        CLS_OP_RELOAD_GO = 4'b1001
    } cls_op_t;
endpackage

// *** tb/cls_host.sv ***
// programming host model driving the command port
`timescale 1ns/10ps
`include "cls_defs.svh"
module cls_host (
    input wire logic clk,
    output logic cmd_valid,
    output logic [3:0] cmd_op,
    output logic [`CLS_AW-1:0] cmd_addr,
    output logic [`CLS_DW-1:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic [`CLS_DW-1:0] rsp_data,
    input wire logic rsp_refused
);
    // idle bus at time zero
    initial
    begin
        cmd_valid = 1'h0;
        cmd_op = 4'h0;
        cmd_addr = 3'h0;
        cmd_data = 8'h00;
    end

    // one command, answer taken one edge later
    task automatic send(input logic [3:0] op, input logic [`CLS_AW-1:0] a,
                        input logic [`CLS_DW-1:0] d, output logic v,
                        output logic [`CLS_DW-1:0] q, output logic r);
        @(posedge clk);
        #2;
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(posedge clk);
        #2;
        v = rsp_valid;
        q = rsp_data;
        r = rsp_refused;
        cmd_valid = 1'h0;
        cmd_addr = ~a; // released bus shows no stale value
        cmd_data = ~d;
    endtask

    // arm and go on consecutive clocks
    task automatic reload();
        @(posedge clk);
        #2;
        cmd_valid = 1'h1;
        cmd_op = cls_pkg::CLS_OP_RELOAD_ARM;
        @(posedge clk);
        #2;
        cmd_op = cls_pkg::CLS_OP_RELOAD_GO;
        @(posedge clk);
        #2;
        cmd_valid = 1'h0;
    endtask
endmodule

// *** tb/tb_top.sv ***
// testbench for the configuration loader and security block
`timescale 1ns/10ps
`include "cls_defs.svh"
module tb_top;
    logic clk, rst, vccint_ok, vccio_ok, pad_over_vccio, cmd_valid, rsp_valid, rsp_refused;
    logic ua_rd, ua_valid, io_oe_n, io_pullup, user_clr, supply_low_output_block, cfg_done;
    logic [3:0] cmd_op;
    logic [`CLS_AW-1:0] cmd_addr, ua_addr;
    logic [`CLS_DW-1:0] cmd_data, rsp_data, ua_data, rd;
    logic [`CLS_CELLS_W-1:0] cfg_cells;
    logic rv, rr;
    int n_errors = 0;
    int total_checks = 0;

    cls_top uut (.clk(clk), .rst(rst), .vccint_ok(vccint_ok), .vccio_ok(vccio_ok),
        .pad_over_vccio(pad_over_vccio), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_refused(rsp_refused), .ua_rd(ua_rd), .ua_addr(ua_addr),
        .ua_valid(ua_valid), .ua_data(ua_data), .io_oe_n(io_oe_n), .io_pullup(io_pullup),
        .user_clr(user_clr), .supply_low_output_block(supply_low_output_block),
        .cfg_done(cfg_done), .cfg_cells(cfg_cells));

    cls_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_refused(rsp_refused));

    // free running clock
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic cmd(input cls_pkg::cls_op_t op, input int a, input logic [7:0] d);
        host.send(op, 3'(a), d, rv, rd, rr);
    endtask

    function automatic logic [7:0] img(input int i, input logic [7:0] k);
        return k + 8'(i) * 8'h13;
    endfunction

    function automatic logic [63:0] image(input logic [7:0] k);
        logic [63:0] c;
        c = 64'h0;
        for (int i = 0; i < 8; i++)
            c[8*i +: 8] = img(i, k);
        return c;
    endfunction

    // whole flash image plus user flash and complete bit
    task automatic program_all(input logic [7:0] k);
        cmd(cls_pkg::CLS_OP_ERASE, 0, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            cmd(cls_pkg::CLS_OP_PROG_CFG, i, img(i, k));
            cmd(cls_pkg::CLS_OP_PROG_UFM, i, img(i, 8'h5C));
        end
        cmd(cls_pkg::CLS_OP_PROG_DONE, 0, 8'h00);
    endtask

    // watch pins through a load, bounded
    task automatic wait_load(input logic exp_oe);
        int i;
        logic clr_seen;
        clr_seen = 1'h0;
        for (i = 0; i < 100 && cfg_done !== 1'h1; i++)
        begin
            check("io_oe_n load", io_oe_n, 64'h1);
            check("io_pullup", io_pullup, 64'h1);
            if (user_clr === 1'h1)
                clr_seen = 1'h1;
            cyc(1);
        end
        if (i == 100)
        begin
            check("load timeout", 64'h1, 64'h0);
            stop_test();
        end
        check("user_clr", clr_seen, 64'h1);
        check("user_clr end", user_clr, 64'h0);
        cyc(2);
        check("io_oe_n after", io_oe_n, 64'(exp_oe));
        check("io_pullup user", io_pullup, 64'h0);
    endtask

    task automatic do_reload(input logic exp_oe);
        int i;
        host.reload();
        for (i = 0; i < 5 && cfg_done !== 1'h0; i++)
            cyc(1);
        check("reload started", cfg_done, 64'h0);
        cyc(1);
        wait_load(exp_oe);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic s_power_up();
        check("supply_low", supply_low_output_block, 64'h1);
        program_all(8'h21);
        vccio_ok = 1'h1;
        cyc(3);
        check("io_oe_n io first", io_oe_n, 64'h1);
        check("cfg_done early", cfg_done, 64'h0);
        vccint_ok = 1'h1;
        wait_load(1'h0);
        check("cells", cfg_cells, image(8'h21));
        check("supply_low", supply_low_output_block, 64'h0);
    endtask

    task automatic s_live_update();
        cmd(cls_pkg::CLS_OP_NOP, 0, 8'h00);
        program_all(8'h47);
        check("cells kept", cfg_cells, image(8'h21));
        check("io_oe_n kept", io_oe_n, 64'h0);
        cmd(cls_pkg::CLS_OP_READ_CFG, 3, 8'h00);
        check("read flash", rd, 64'(img(3, 8'h47)));
        do_reload(1'h0);
        check("cells new", cfg_cells, image(8'h47));
    endtask

    task automatic s_refused_reload();
        cmd(cls_pkg::CLS_OP_RELOAD_GO, 0, 8'h00);
        cyc(3);
        check("lone go", cfg_done, 64'h1);
        cmd(cls_pkg::CLS_OP_RELOAD_ARM, 0, 8'h00);
        cmd(cls_pkg::CLS_OP_READ_UFM, 0, 8'h00);
        cmd(cls_pkg::CLS_OP_RELOAD_GO, 0, 8'h00);
        cyc(3);
        check("disarmed go", cfg_done, 64'h1);
    endtask

    task automatic s_supply_faults();
        vccio_ok = 1'h0;
        cyc(2);
        check("io_oe_n io low", io_oe_n, 64'h1);
        check("supply_low io", supply_low_output_block, 64'h1);
        vccio_ok = 1'h1;
        cyc(2);
        check("io_oe_n back", io_oe_n, 64'h0);
        pad_over_vccio = 1'h1;
        cyc(2);
        check("io_oe_n pad", io_oe_n, 64'h1);
        pad_over_vccio = 1'h0;
        cyc(2);
        check("io_oe_n pad off", io_oe_n, 64'h0);
    endtask

    task automatic s_security();
        cmd(cls_pkg::CLS_OP_READ_CFG, 5, 8'h00);
        check("cfg open", {rv, rr, rd}, {2'h2, img(5, 8'h47)});
        cmd(cls_pkg::CLS_OP_PROG_SEC, 0, 8'h00);
        cmd(cls_pkg::CLS_OP_READ_CFG, 5, 8'h00);
        check("cfg locked", {rv, rr, rd}, {2'h3, 8'h00});
        cmd(cls_pkg::CLS_OP_READ_UFM, 2, 8'h00);
        check("ufm port", {rv, rr, rd}, {2'h2, img(2, 8'h5C)});
        ua_rd = 1'h1;
        ua_addr = 3'h6;
        cyc(1);
        ua_rd = 1'h0;
        ua_addr = 3'h1;
        check("ufm array", {ua_valid, ua_data}, {1'h1, img(6, 8'h5C)});
        cmd(cls_pkg::CLS_OP_PROG_UFM, 1, img(1, 8'h5C));
        do_reload(1'h0);
        cmd(cls_pkg::CLS_OP_READ_CFG, 5, 8'h00);
        check("still locked", rr, 64'h1);
        cmd(cls_pkg::CLS_OP_ERASE, 0, 8'h00);
        cmd(cls_pkg::CLS_OP_READ_CFG, 5, 8'h00);
        check("erased open", {rr, rd}, {1'h0, `CLS_ERASED});
    endtask

    task automatic s_no_complete();
        do_reload(1'h1);
        check("cells erased", cfg_cells, {8{`CLS_ERASED}});
        cyc(3);
        check("io_oe_n held", io_oe_n, 64'h1);
    endtask

    // main sequence
    initial
    begin
        rst = 1'h1;
        vccint_ok = 1'h0;
        vccio_ok = 1'h0;
        pad_over_vccio = 1'h0;
        ua_rd = 1'h0;
        ua_addr = 3'h0;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'h0;
        s_power_up();
        s_live_update();
        s_refused_reload();
        s_supply_faults();
        s_security();
        s_no_complete();
        stop_test();
    end
endmodule
